// *** src/ezl_loader.sv ***
// zone3 configuration and zone4 function-access loader
//
// Behaviour
// - zone3 data bit15 set means more words
// - zone3 bits 14:8 select config byte
// - zone3 bits 7:0 are new byte value
// - only listed config bytes may be written
// - zone4 configures port before pci access
// - zone4 entry is two words, one access
// - zone4 read performed, returned data discarded
// - bits 14:12 pick bar0 or bar1
// - bit 11 chooses read or write
// - bits 7:0 give io byte offset
// - second word bit15 clear ends program
// - second word bits 7:0 are write data
// - retry every pci access while loading
// - zone3 header bit15 starts function, 2:0
`timescale 1ns/1ps

module ezl_loader
   import ezl_pkg::*;
(
   input  wire logic               clk_i,      // pci clock, 40 mhz
   input  wire logic               rst_i,      // async reset, active high
   input  wire logic               start_i,    // pulse: header read, zones begin
   input  wire logic [1:0]         zones_i,    // header bits: [1] zone3, [0] zone4
   input  wire ezl_pkg::ezl_word_s word_i,     // next eeprom word, valid pulse
   output logic                    word_rdy_o, // loader can take a word
   input  wire logic               fn_ack_i,   // function access complete
   output ezl_pkg::ezl_cfg_s       cfg_o,      // configuration byte write
   output ezl_pkg::ezl_fn_s        fn_o,       // function access request
   output logic                    retry_o,    // retry pci accesses
   output logic                    done_o      // program finished, level
);
   import ezl_pkg::*;

   // registered loader state and its next value
   ezl_state_s state_q;
   ezl_state_s state_d;

   // flow of one program
   //  idle      waits for start_i; zones_i tells which zones follow
   //  z3 hdr    a header with bit 15 set opens a function, clear ends
   //            zone3 and moves on to zone4 or to the end
   //  z3 data   each word carries offset and value; bit 15 clear hands
   //            control back to the header state
   //  z4 w1     first word of a pair: bar code, direction, io offset
   //  z4 w2     second word: write data and continuation flag
   //  z4 acc    the access is held on fn_o until fn_ack_i answers
   //
   // while any state but idle is active retry_o stands, so the host
   // sees retries until the program is complete and done_o rises
   //
   // words are taken only on an edge where word_i.valid meets
   // word_rdy_o; the reader may insert any number of idle cycles
   // between words, and back-to-back words are accepted
   //
   // refusals
   //  - a data word for a function other than zero is consumed only
   //  - a data word for a byte outside the writable set is consumed only
   //  - the status byte keeps its capability bit and clears the rest
   //  - a pair naming a reserved bar code is consumed and skipped
   //
   // limitations
   //  - there is no time-out on fn_ack_i: a function that never
   //    answers leaves the loader waiting and retry_o standing
   //  - start_i is ignored outside idle; a new program needs the
   //    previous one to end or a reset
   //  - read data of a zone4 read is not brought into the loader
   //

   // fields of the word on the input, decoded once
   logic       w_more;      // bit 15: more words or pairs follow
   logic [6:0] w_ofs;       // zone3 configuration byte offset
   logic [7:0] w_byte;      // low byte: value, io offset or write data
   logic [2:0] w_func;      // zone3 header function number
   logic [2:0] w_bar;       // zone4 base address register code
   logic       w_dir;       // zone4 direction, set for write
   logic       w_take;      // a word is offered and wanted

   // continuation flag, shared by zone3 words and zone4 second words
   // and by the zone3 header, where it opens a function
   function automatic logic word_more(input logic [15:0] w);
      word_more = w[Z3_MORE_BIT];
   endfunction

   // configuration byte offset of a zone3 data word
   // seven bits: the writable set lies below 0x44
   function automatic logic [6:0] word_ofs(input logic [15:0] w);
      word_ofs = w[Z3_OFS_HI:Z3_OFS_LO];
   endfunction

   // low byte of a word
   // a configuration value, an io offset or write data by state
   function automatic logic [7:0] word_byte(input logic [15:0] w);
      word_byte = w[Z3_VAL_HI:Z3_VAL_LO];
   endfunction

   // function number of a zone3 header
   // the reserved bits above it are not looked at
   function automatic logic [2:0] word_func(input logic [15:0] w);
      word_func = w[Z3_FUNC_HI:0];
   endfunction

   // base address register code of a zone4 first word
   // three bits, of which only two codes are in use
   function automatic logic [2:0] word_bar(input logic [15:0] w);
      word_bar = w[Z4_BAR_HI:Z4_BAR_LO];
   endfunction

   // only codes for bar 0 and bar 1 lead to an access
   // anything else would address nothing in this device
   function automatic logic bar_usable(input logic [2:0] code);
      bar_usable = (code == Z4_BAR0) || (code == Z4_BAR1);
   endfunction

   // value stored for a permitted byte; status keeps only bit 4
   // so reserved status bits can never be set by a program
   function automatic logic [7:0] cfg_value(input logic [6:0] ofs, input logic [7:0] val);
      if (ofs == OFS_STATUS_CAPABILITY)
      begin
         cfg_value = val & STATUS_CAP_MASK;
      end
      else
      begin
         cfg_value = val;
      end
   endfunction

   // zone3 fields of the input word
   assign w_more = word_more(word_i.data);
   assign w_ofs  = word_ofs(word_i.data);
   assign w_byte = word_byte(word_i.data);
   assign w_func = word_func(word_i.data);

   // zone4 fields and the take strobe
   assign w_bar  = word_bar(word_i.data);
   assign w_dir  = word_i.data[Z4_DIR_BIT];
   assign w_take = word_i.valid & state_q.word_rdy;

   // next state of the loader
   always_comb
   begin
      state_d        = state_q;
      state_d.cfg.we = 1'b0;
      case (state_q.state)
         // waiting for the header; zones chosen from its presence bits
         ST_IDLE:
         begin
            state_d.word_rdy = 1'b0;
            if (start_i)
            begin
               state_d.busy  = 1'b1;
               state_d.done  = 1'b0;
               state_d.z4_en = zones_i[HDR_Z4_BIT];
               if (zones_i[HDR_Z3_BIT])
               begin
                  state_d.state    = ST_Z3HDR;
                  state_d.word_rdy = 1'b1;
               end
               else if (zones_i[HDR_Z4_BIT])
               begin
                  state_d.state    = ST_Z4W1;
                  state_d.word_rdy = 1'b1;
               end
               else
               begin
                  // nothing to load: finish at once
                  state_d.busy = 1'b0;
                  state_d.done = 1'b1;
               end
            end
         end

         // function header: open a function or close zone3
         ST_Z3HDR:
         begin
            if (w_take)
            begin
               if (w_more)
               begin
                  // only function zero is implemented
                  state_d.func_ok = (w_func == Z3_FUNC_ZERO);
                  state_d.state   = ST_Z3DATA;
               end
               else if (state_q.z4_en)
               begin
                  // zone4 follows, keep asking for words
                  state_d.state = ST_Z4W1;
               end
               else
               begin
                  // no zone4: the program ends here
                  state_d.state    = ST_IDLE;
                  state_d.word_rdy = 1'b0;
                  state_d.busy     = 1'b0;
                  state_d.done     = 1'b1;
               end
            end
         end

         // data word: write one permitted byte of a valid function
         ST_Z3DATA:
         begin
            if (w_take)
            begin
               state_d.cfg.ofs = w_ofs;
               state_d.cfg.val = cfg_value(w_ofs, w_byte);
               // refused bytes and unknown functions write nothing
               state_d.cfg.we  = state_q.func_ok & ezl_writable(w_ofs);
               if (!w_more)
               begin
                  // last word of the function: a header comes next
                  state_d.state = ST_Z3HDR;
               end
            end
         end

         // first word of a pair: target, direction and io offset
         ST_Z4W1:
         begin
            if (w_take)
            begin
               state_d.fn.wr   = w_dir;
               state_d.fn.bar  = (w_bar == Z4_BAR1);
               state_d.bad_bar = ~bar_usable(w_bar);
               state_d.fn.addr = w_byte;
               state_d.state   = ST_Z4W2;
            end
         end

         // second word of a pair: data and continuation
         ST_Z4W2:
         begin
            if (w_take)
            begin
               state_d.fn.wdata = w_byte;
               state_d.fn_more  = w_more;
               // no further words while the access runs
               state_d.word_rdy = 1'b0;
               // a reserved bar code skips the access
               state_d.fn.req   = ~state_q.bad_bar;
               state_d.state    = ST_Z4ACC;
            end
         end

         // access in flight; read data is never captured
         ST_Z4ACC:
         begin
            if (fn_ack_i || !state_q.fn.req)
            begin
               state_d.fn.req = 1'b0;
               if (state_q.fn_more)
               begin
                  // another pair follows
                  state_d.state    = ST_Z4W1;
                  state_d.word_rdy = 1'b1;
               end
               else
               begin
                  // last pair: the whole program is finished
                  state_d.state = ST_IDLE;
                  state_d.busy  = 1'b0;
                  state_d.done  = 1'b1;
               end
            end
         end

         // unused codes fall back to a clean idle
         default:
         begin
            state_d = '0;
         end
      endcase
   end

   // state register; reset leaves every output low
   // and the loader idle until the next start
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // word handshake towards the reader
   assign word_rdy_o = state_q.word_rdy;

   // configuration and function requests
   assign cfg_o      = state_q.cfg;
   assign fn_o       = state_q.fn;

   // progress levels seen by the host side
   assign retry_o    = state_q.busy;
   assign done_o     = state_q.done;

endmodule // ezl_loader

// *** pkg/ezl_pkg.sv ***
// package for the eeprom zone3/zone4 configuration loader
package ezl_pkg;

   // zone3 data word field positions
   localparam int unsigned Z3_MORE_BIT   = 15;
   localparam int unsigned Z3_OFS_HI     = 14;
   localparam int unsigned Z3_OFS_LO     = 8;
   localparam int unsigned Z3_VAL_HI     = 7;
   localparam int unsigned Z3_VAL_LO     = 0;
   localparam int unsigned Z3_FUNC_HI    = 2;
   localparam logic [2:0]  Z3_FUNC_ZERO  = 3'h0;

   // zone4 word field positions
   localparam int unsigned Z4_BAR_HI     = 14;
   localparam int unsigned Z4_BAR_LO     = 12;
   localparam int unsigned Z4_DIR_BIT    = 11;
   localparam logic [2:0]  Z4_BAR0       = 3'h0;
   localparam logic [2:0]  Z4_BAR1       = 3'h1;

   // header zone-presence bits
   localparam int unsigned HDR_Z3_BIT    = 1;
   localparam int unsigned HDR_Z4_BIT    = 0;

   // eeprom-writable configuration byte offsets
   localparam logic [6:0] OFS_DEVICE_IDENT_LOW    = 7'h02;
   localparam logic [6:0] OFS_DEVICE_IDENT_HIGH   = 7'h03;
   localparam logic [6:0] OFS_STATUS_CAPABILITY   = 7'h06;
   localparam logic [6:0] OFS_CLASS_CODE_LOW      = 7'h09;
   localparam logic [6:0] OFS_CLASS_CODE_MID      = 7'h0A;
   localparam logic [6:0] OFS_CLASS_CODE_HIGH     = 7'h0B;
   localparam logic [6:0] OFS_SUBSYSTEM_IDENT_LOW = 7'h2E;
   localparam logic [6:0] OFS_SUBSYSTEM_IDENT_HI  = 7'h2F;
   localparam logic [6:0] OFS_INTERRUPT_PIN       = 7'h3D;
   localparam logic [6:0] OFS_POWER_CAPS_LOW      = 7'h42;
   localparam logic [6:0] OFS_POWER_CAPS_HIGH     = 7'h43;
   localparam logic [7:0] STATUS_CAP_MASK         = 8'h10;

   // loader states
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_Z3HDR  = 3'b001,
      ST_Z3DATA = 3'b010,
      ST_Z4W1   = 3'b011,
      ST_Z4W2   = 3'b100,
      ST_Z4ACC  = 3'b101
   } ezl_state_e;

   // word request / answer towards the eeprom reader
   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } ezl_word_s;

   // configuration byte write
   typedef struct packed {
      logic       we;
      logic [6:0] ofs;
      logic [7:0] val;
   } ezl_cfg_s;

   // function access towards the parallel port
   typedef struct packed {
      logic       req;
      logic       wr;
      logic       bar;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ezl_fn_s;

   // whole module state
   typedef struct packed {
      ezl_state_e state;
      logic       busy;
      logic       done;
      logic       word_rdy;
      logic       z4_en;
      logic       func_ok;
      ezl_cfg_s   cfg;
      ezl_fn_s    fn;
      logic       fn_more;
      logic       bad_bar;
   } ezl_state_s;

   // eeprom writable byte check
   function automatic logic ezl_writable(input logic [6:0] ofs);
      case (ofs)
         OFS_DEVICE_IDENT_LOW, OFS_DEVICE_IDENT_HIGH, OFS_STATUS_CAPABILITY,
         OFS_CLASS_CODE_LOW, OFS_CLASS_CODE_MID, OFS_CLASS_CODE_HIGH,
         OFS_SUBSYSTEM_IDENT_LOW, OFS_SUBSYSTEM_IDENT_HI, OFS_INTERRUPT_PIN,
         OFS_POWER_CAPS_LOW, OFS_POWER_CAPS_HIGH: ezl_writable = 1'b1;
         default: ezl_writable = 1'b0;
      endcase
   endfunction

endpackage

// *** dv/ezl_loader_properties.sv ***
// port assertions for the zone loader
`timescale 1ns/1ps
module ezl_loader_properties
   import ezl_pkg::*;
(
   input wire logic              clk_i,      // clock
   input wire logic              rst_i,      // reset
   input wire ezl_pkg::ezl_word_s word_i,    // word in
   input wire logic              word_rdy_o, // ready
   input wire logic              fn_ack_i,   // ack
   input wire ezl_pkg::ezl_cfg_s cfg_o,      // byte write
   input wire ezl_pkg::ezl_fn_s  fn_o,       // access
   input wire logic              retry_o,    // retry
   input wire logic              done_o      // done
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // accepted word, finished access
   sequence s_take; word_i.valid && word_rdy_o; endsequence
   sequence s_ack; fn_o.req && fn_ack_i; endsequence
   a_we_in_load: assert property (cfg_o.we |-> retry_o) else $error("write outside load");
   a_req_in_load: assert property (fn_o.req |-> retry_o) else $error("access outside load");
   a_ofs_legal: assert property (cfg_o.we |-> ezl_writable(cfg_o.ofs)) else $error("bad ofs");
   a_status_mask: assert property (cfg_o.we && cfg_o.ofs == 7'h06 |-> (cfg_o.val & 8'hEF) == 8'h00)
      else $error("status bits");
   a_cfg_from_word: assert property (cfg_o.we |-> $past(word_i.valid && word_rdy_o)
      && cfg_o.ofs == $past(word_i.data[14:8])) else $error("cfg not from word");
   a_req_holds: assert property (fn_o.req && !fn_ack_i |=> fn_o.req && $stable(fn_o))
      else $error("req moved");
   a_req_drops: assert property (s_ack |=> !fn_o.req) else $error("req stuck");
   a_req_after_word: assert property (s_take ##1 fn_o.req |-> !word_rdy_o)
      else $error("words during access");
   a_done_quiet: assert property (done_o |-> !retry_o && !word_rdy_o) else $error("done busy");
endmodule // ezl_loader_properties
bind ezl_loader ezl_loader_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .word_i(word_i),
   .word_rdy_o(word_rdy_o), .fn_ack_i(fn_ack_i), .cfg_o(cfg_o), .fn_o(fn_o),
   .retry_o(retry_o), .done_o(done_o));

// *** dv/ezl_eeprom_model.sv ***
// eeprom word source and port access responder
`timescale 1ns/1ps
module ezl_eeprom_model
   import ezl_pkg::*;
(
   input  wire logic         clk_i,  // clock
   input  wire logic         rst_i,  // reset
   input  wire logic         rdy_i,  // loader wants words
   input  wire logic         req_i,  // access pending
   output ezl_pkg::ezl_word_s word_o, // word out
   output logic              ack_o   // access done
);
   logic [15:0] mem [0:63]; // program, filled by bench
   int          n;
   int          idx;
   int          cnt;
   logic        stall_q;
   logic [15:0] last_q;
   // offer a word when asked; idle data is the inverse of the last word
   assign word_o.valid = rdy_i && !stall_q && idx < n;
   assign word_o.data = word_o.valid ? mem[idx] : ~last_q;
   // advance on take, stall at random, ack accesses late
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idx <= 0;
         cnt <= 0;
         stall_q <= 1'b0;
         last_q <= 16'h0000;
         ack_o <= 1'b0;
      end
      else
      begin
         stall_q <= ($urandom % 4) == 0;
         if (word_o.valid)
         begin
            idx <= idx + 1;
            last_q <= word_o.data;
         end
         if (ack_o) ack_o <= 1'b0;
         else if (!req_i) cnt <= $urandom % 3;
         else if (cnt == 0) ack_o <= 1'b1;
         else cnt <= cnt - 1;
      end
   end
endmodule // ezl_eeprom_model

// *** dv/tb_top.sv ***
// self-checking bench for the zone loader
`timescale 1ns/1ps
module tb_top;
   import ezl_pkg::*;
   logic       clk_i = 0, rst_i = 1, start_i = 0, fn_ack_i, word_rdy_o, retry_o, done_o, seen;
   logic [1:0] zones_i = 2'h0;
   ezl_word_s  word_i;
   ezl_cfg_s   cfg_o;
   ezl_fn_s    fn_o;
   int         errors = 0, n_tests = 0, cyc = 0;
   logic [17:0] qc [$], qf [$];
   logic [6:0] ofs_t [0:12] = '{7'h02, 7'h03, 7'h06, 7'h09, 7'h0A, 7'h0B, 7'h2E, 7'h2F, 7'h3D,
                                7'h42, 7'h43, 7'h00, 7'h3C};
   ezl_loader uut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .zones_i(zones_i),
      .word_i(word_i), .word_rdy_o(word_rdy_o), .fn_ack_i(fn_ack_i), .cfg_o(cfg_o),
      .fn_o(fn_o), .retry_o(retry_o), .done_o(done_o));
   ezl_eeprom_model eep (.clk_i(clk_i), .rst_i(rst_i), .rdy_i(word_rdy_o), .req_i(fn_o.req),
      .word_o(word_i), .ack_o(fn_ack_i));
   task automatic check(input logic [17:0] s, input logic [17:0] e);
      n_tests++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one program: build words and expected results, run to done
   task automatic run(input logic [1:0] z, input int nd, input int np);
      int k, i, r, w;
      k = 0;
      rst_i <= 1'b1;
      if (z[1])
      begin
         eep.mem[k++] = 16'h8001;
         eep.mem[k++] = 16'h0211;
         eep.mem[k++] = 16'h8000;
         for (i = 0; i < nd; i++)
         begin
            r = $urandom % 13;
            w = $urandom % 256;
            eep.mem[k++] = {i < nd - 1, ofs_t[r], w[7:0]};
            if (r < 11) qc.push_back({ofs_t[r], r == 2 ? w[7:0] & 8'h10 : w[7:0]});
         end
         eep.mem[k++] = 16'h0000;
      end
      for (i = 0; z[0] && i < np; i++)
      begin
         r = $urandom % 3;
         w = $urandom;
         eep.mem[k++] = {1'b1, r[2:0], w[8], 3'h0, w[7:0]};
         eep.mem[k++] = {i < np - 1, 7'h00, w[16:9]};
         if (r < 2) qf.push_back({w[8], r[0], w[7:0], w[8] ? w[16:9] : 8'h00});
      end
      eep.n = k;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      start_i <= 1'b1;
      zones_i <= z;
      @(posedge clk_i);
      start_i <= 1'b0;
      for (i = 0; i < 2000 && done_o !== 1'b1; i++) @(negedge clk_i);
      check(done_o, 1'b1);
      check(retry_o, 1'b0);
      check(qc.size() + qf.size(), 0);
      qc.delete();
      qf.delete();
   endtask
   initial forever #12.5 clk_i = ~clk_i;
   // compare each byte write and each new access with the model queues
   always @(negedge clk_i)
   begin
      if (cfg_o.we)
      begin
         check(retry_o, 1'b1);
         check({cfg_o.ofs, cfg_o.val}, qc.size() ? qc.pop_front() : '1);
      end
      if (fn_o.req && seen !== 1'b1)
      begin
         check(word_rdy_o, 1'b0);
         check({fn_o.wr, fn_o.bar, fn_o.addr, fn_o.wr ? fn_o.wdata : 8'h00},
               qf.size() ? qf.pop_front() : '1);
      end
      seen = fn_o.req;
   end
   // cycle ceiling against hangs
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         finish_test();
      end
   end
   initial
   begin
      void'($urandom(59639));
      run(2'b11, 12, 6);
      run(2'b10, 3, 0);
      run(2'b01, 0, 4);
      run(2'b00, 0, 0);
      repeat (50) run(2'b11, 1 + $urandom % 8, 1 + $urandom % 4);
      finish_test();
   end
endmodule // tb_top
